/* File: rtl/led_channel_output_control.sv */
// output control: current, phase, detect, thermal, dc and spread
`timescale 1ns/100ps
`default_nettype none
`include "led_output_defines.svh"
module led_channel_output_control
  import led_output_pkg::*;
(
  input  wire logic         sys_clk,
  input  wire logic         resetn,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  input  wire logic [7:0]   reg_addr,
  input  wire logic [7:0]   reg_wdata,
  output logic      [7:0]   reg_rdata,
  input  wire logic         hardware_shutdown_pin,
  input  wire logic         software_shutdown_bit,
  input  wire logic [1:0]   pwm_resolution_select,
  input  wire logic [287:0] pwm_pending,
  input  wire logic [143:0] channel_current_scale,
  input  wire logic [17:0]  led_open_sense,
  input  wire logic [17:0]  led_short_sense,
  input  wire logic [3:0]   die_over_temp,
  output logic      [17:0]  led_on,
  output logic      [287:0] led_current,
  output logic              spread_enable,
  output logic      [1:0]   spread_range,
  output logic      [1:0]   spread_cycle_time,
  output logic              iface_reset,
  output logic              regs_reset
);
  // --------------------------------
  // pin synchronisers
  // --------------------------------
  localparam int SW = 41;
  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;
  logic [SW-1:0] sync3_q;
  logic [SW-1:0] pins_q;
  logic [SW-1:0] pins_raw;

  assign pins_raw = {hardware_shutdown_pin, die_over_temp,
                     led_short_sense, led_open_sense};

  // three stages; a bit moves once stages two and three agree
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sync1_q <= `PIN_RST;  // pin bit idles high
      sync2_q <= `PIN_RST;
      sync3_q <= `PIN_RST;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // filtered pin levels
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pins_q <= `PIN_RST;
    end else begin
      for (int i = 0; i < SW; i++) begin
        if (sync2_q[i] == sync3_q[i]) begin
          pins_q[i] <= sync3_q[i];
        end
      end
    end
  end

  logic        run_lvl;
  logic [3:0]  temp_lvl;
  logic [17:0] short_lvl;
  logic [17:0] open_lvl;
  logic        run_prev_q;

  assign run_lvl   = pins_q[40];
  assign temp_lvl  = pins_q[39:36];
  assign short_lvl = pins_q[35:18];
  assign open_lvl  = pins_q[17:0];

  // --------------------------------
  // shutdown pin edge and register strobes
  // --------------------------------
  logic active_ok;
  logic soft_rst;
  logic upd_cmd;

  assign active_ok = run_lvl & software_shutdown_bit;
  assign soft_rst  = reg_wr && (reg_addr == `OFS_SOFT_RESET) &&
                     (reg_wdata == `CMD_ZERO) && active_ok;  // [RULE20]
  assign upd_cmd   = reg_wr && (reg_addr == `OFS_UPDATE) &&
                     (reg_wdata == `CMD_ZERO) && active_ok;  // [RULE23]

  // pin edge detect; registers are left alone
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      run_prev_q  <= 1'b1;
      iface_reset <= 1'b0;
    end else begin
      run_prev_q  <= run_lvl;
      iface_reset <= run_lvl & ~run_prev_q;       // [RULE24]
    end
  end

  // tells the per-channel register file outside to clear too
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      regs_reset <= 1'b0;
    end else begin
      regs_reset <= soft_rst;                     // [RULE20]
    end
  end

  // --------------------------------
  // writable registers
  // --------------------------------
  logic [7:0] gain_q;
  logic [7:0] phase_q;
  logic [7:0] detect_q;
  logic [7:0] thermal_q;
  logic [7:0] spread_q;

  // global current code
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      gain_q <= `RST_BYTE;
    end else if (soft_rst) begin
      gain_q <= `RST_BYTE;
    end else if (reg_wr && reg_addr == `OFS_GLOBAL_CURR) begin
      gain_q <= reg_wdata;
    end
  end

  // phase setup; unused bits stay zero
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      phase_q <= `RST_BYTE;
    end else if (soft_rst) begin
      phase_q <= `RST_BYTE;
    end else if (reg_wr && reg_addr == `OFS_PHASE) begin
      phase_q <= reg_wdata & `PH_WR_MASK;         // [RULE25]
    end
  end

  // detect select
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      detect_q <= `RST_BYTE;
    end else if (soft_rst) begin
      detect_q <= `RST_BYTE;
    end else if (reg_wr && reg_addr == `OFS_DETECT) begin
      detect_q <= reg_wdata & `DET_WR_MASK;       // [RULE25]
    end
  end

  // thermal roll-off and threshold; flag bit is not stored
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      thermal_q <= `RST_BYTE;
    end else if (soft_rst) begin
      thermal_q <= `RST_BYTE;
    end else if (reg_wr && reg_addr == `OFS_THERMAL) begin
      thermal_q <= reg_wdata & `TH_WR_MASK;       // [RULE25]
    end
  end

  // dc mode and spread-spectrum setup
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      spread_q <= `RST_BYTE;
    end else if (soft_rst) begin
      spread_q <= `RST_BYTE;
    end else if (reg_wr && reg_addr == `OFS_SPREAD) begin
      spread_q <= reg_wdata;
    end
  end

  // spread settings go to the oscillator
  assign spread_enable     = spread_q[`SS_ENABLE_BIT];  // [RULE17]
  assign spread_range      = spread_q[3:2];             // [RULE18]
  assign spread_cycle_time = spread_q[1:0];             // [RULE19]

  // --------------------------------
  // open / short detection
  // --------------------------------
  detect_mode_e det_new;
  logic [17:0]  fault_q;

  assign det_new = detect_mode_e'(reg_wdata[1:0]);

  // capture on a write taking the field from 00 to 10 or 11
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fault_q <= '0;
    end else if (soft_rst) begin
      fault_q <= '0;
    end else if (reg_wr && reg_addr == `OFS_DETECT &&
                 detect_q[1:0] == DET_OFF0) begin    // [RULE8]
      case (det_new)
        DET_SHORT: fault_q <= short_lvl;             // [RULE5] [RULE7]
        DET_OPEN:  fault_q <= open_lvl;              // [RULE5] [RULE7]
        default:   fault_q <= fault_q;
      endcase
    end
  end

  // --------------------------------
  // thermal flag and roll-off
  // --------------------------------
  logic       temp_flag;
  logic [7:0] rolloff_frac;

  // threshold 00..11 picks comparator 140,120,100,90 degrees
  assign temp_flag = temp_lvl[thermal_q[1:0]];       // [RULE9] [RULE11]

  always_comb begin
    case (thermal_q[7:6])                            // [RULE10]
      2'h0:    rolloff_frac = `FRAC_100;
      2'h1:    rolloff_frac = `FRAC_75;
      2'h2:    rolloff_frac = `FRAC_55;
      default: rolloff_frac = `FRAC_30;
    endcase
  end

  // --------------------------------
  // register read
  // --------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `OFS_GLOBAL_CURR: reg_rdata <= gain_q;
        `OFS_PHASE:       reg_rdata <= phase_q;
        `OFS_DETECT:      reg_rdata <= detect_q;
        `OFS_STAT_LOW:    reg_rdata <= fault_q[7:0];    // [RULE6]
        `OFS_STAT_MID:    reg_rdata <= fault_q[15:8];   // [RULE6]
        `OFS_STAT_HIGH:   reg_rdata <= {6'h00, fault_q[17:16]}; // [RULE6]
        `OFS_THERMAL:     reg_rdata <= {thermal_q[7:6], 1'b0,
                                        temp_flag, 2'h0,
                                        thermal_q[1:0]}; // [RULE11]
        `OFS_SPREAD:      reg_rdata <= spread_q;
        default:          reg_rdata <= 8'h00;
      endcase
    end
  end

  // --------------------------------
  // pwm timebase
  // --------------------------------
  logic [7:0]  osc_acc_q;
  logic [8:0]  osc_sum;
  logic        osc_tick;
  logic [15:0] pwm_cnt_q;
  logic [15:0] res_mask;
  logic [15:0] res_third;
  logic [15:0] res_half;

  assign osc_sum  = {1'b0, osc_acc_q} + {1'b0, `OSC_STEP};
  assign osc_tick = (osc_sum >= {1'b0, `OSC_WRAP});

  // 16 MHz tick stream from the system clock
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      osc_acc_q <= 8'h00;
    end else if (osc_tick) begin
      osc_acc_q <= 8'(osc_sum - {1'b0, `OSC_WRAP});  // [RULE21]
    end else begin
      osc_acc_q <= osc_sum[7:0];
    end
  end

  // resolution from the control register, 8-bit after reset
  always_comb begin
    case (pwm_res_e'(pwm_resolution_select))       // [RULE22]
      RES_8:   begin res_mask = `MASK_8;  res_third = `THIRD_8;  end
      RES_10:  begin res_mask = `MASK_10; res_third = `THIRD_10; end
      RES_12:  begin res_mask = `MASK_12; res_third = `THIRD_12; end
      default: begin res_mask = `MASK_16; res_third = `THIRD_16; end
    endcase
  end

  assign res_half = {1'b0, res_mask[15:1]} + 16'h0001;

  // period counter wraps at N-1
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pwm_cnt_q <= 16'h0000;
    end else if (osc_tick) begin
      pwm_cnt_q <= (pwm_cnt_q + 16'h0001) & res_mask; // [RULE21]
    end
  end

  // --------------------------------
  // group phase offsets
  // --------------------------------
  logic [15:0] grp_phase [3];
  logic        delay_on;

  assign delay_on = phase_q[`PH_DELAY_BIT];        // [RULE2]

  always_comb begin
    for (int g = 0; g < 3; g++) begin
      grp_phase[g] = pwm_cnt_q;
      if (delay_on) begin
        grp_phase[g] = grp_phase[g] - 16'(g) * res_third; // [RULE3]
      end
      if (phase_q[g]) begin
        grp_phase[g] = grp_phase[g] + res_half;    // [RULE4]
      end
      grp_phase[g] = grp_phase[g] & res_mask;
    end
  end

  // --------------------------------
  // active pwm values
  // --------------------------------
  logic [287:0] pwm_active_q;

  // pending values move over on the update command only
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pwm_active_q <= '0;
    end else if (soft_rst) begin
      pwm_active_q <= '0;
    end else if (upd_cmd) begin
      pwm_active_q <= pwm_pending;                 // [RULE23]
    end
  end

  // --------------------------------
  // channel outputs
  // --------------------------------
  for (genvar c = 0; c < 18; c++) begin : g_ch
    logic [15:0] peak;
    logic [23:0] limited;

    // gain/256 times scale/256, cut by roll-off when hot
    assign peak    = gain_q * channel_current_scale[c*8 +: 8]; // [RULE1]
    assign limited = temp_flag ? peak * rolloff_frac
                               : {peak, 8'h00} >> 1;          // [RULE10]

    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        led_current[c*16 +: 16] <= 16'h0000;
      end else begin
        led_current[c*16 +: 16] <= limited[22:7]; // [RULE16]
      end
    end

    pwm_cell u_cell (
      .sys_clk   (sys_clk),
      .resetn    (resetn),
      .phase_cnt (grp_phase[c/6]),
      .duty      (pwm_active_q[c*16 +: 16]),          // [RULE22]
      .res_mask  (res_mask),
      .dc_mode   (c < 12 ? spread_q[5] : spread_q[6]), // [RULE13]
      .run       (active_ok),
      .led_on    (led_on[c])
    );
  end
endmodule
`default_nettype wire

/* File: rtl/led_output_defines.svh */
// register offsets, field positions, reset values and timing counts
// Operation
// [RULE1] peak current is global code over 256 times channel scale over 256
// [RULE2] group delay runs only while phase register bit 7 is one
// [RULE3] three groups of six; groups 2 and 3 lag by thirds of a period
// [RULE4] per-group select bit shifts that group's phase by half a period
// [RULE5] detect field: 00/01 none, 10 short, 11 open; one kind kept
// [RULE6] one result bit per output over three status bytes
// [RULE7] result bit is one when the selected fault was seen
// [RULE8] detect field going from 00 to 1x captures results at once
// [RULE9] threshold field picks roll-off start 140/120/100/90 degrees
// [RULE10] over threshold, current limited to 100/75/55/30 percent
// [RULE11] temperature register bit 4 flags die over selected threshold
// [RULE12] host rewrites roll-off and threshold fields before each read
// [RULE13] dc field bit 0 forces outputs 1-12 on, bit 1 outputs 13-18
// [RULE14] without dc mode duty follows pwm value, 0/N to (N-1)/N
// [RULE15] a duty of exactly one step leaves the output off
// [RULE16] dc mode outputs depend only on global code and scale
// [RULE17] spread bit 4 enables spread-spectrum on the pwm clock
// [RULE18] range field sets deviation 5/15/24/34 percent
// [RULE19] cycle field sets sweep 1980/1200/820/660 microseconds
// [RULE20] zero written to reset register, pin high, bit set: all defaults
// [RULE21] after reset 8-bit resolution at 16 MHz, about 62 kHz
// [RULE22] 18 channels each dimmed by a pwm pair, up to 65536 steps
// [RULE23] zero written to update register moves pending pwm to active
// [RULE24] rising shutdown pin edge resets serial logic, registers kept
// [RULE25] unused bits of these registers read zero, writes ignored
`ifndef LED_OUTPUT_DEFINES_SVH
`define LED_OUTPUT_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_UPDATE        8'h49
`define OFS_GLOBAL_CURR   8'h6e
`define OFS_PHASE         8'h70
`define OFS_DETECT        8'h71
`define OFS_STAT_LOW      8'h72
`define OFS_STAT_MID      8'h73
`define OFS_STAT_HIGH     8'h74
`define OFS_THERMAL       8'h77
`define OFS_SPREAD        8'h78
`define OFS_SOFT_RESET    8'h7f
`define CMD_ZERO          8'h00

// ----------------------------------------------------------------
// reset values and field positions
// ----------------------------------------------------------------
`define RST_BYTE          8'h00
`define PIN_RST           41'h100_0000_0000
`define PH_DELAY_BIT      7
`define TH_FLAG_BIT       4
`define SS_ENABLE_BIT     4
`define PH_WR_MASK        8'h87
`define DET_WR_MASK       8'h03
`define TH_WR_MASK        8'hc3

// ----------------------------------------------------------------
// timebase: 16 MHz pwm oscillator made from 200 MHz by accumulator
// ----------------------------------------------------------------
`define SYS_CLK_MHZ       200
`define OSC_CLK_MHZ       16
`define OSC_STEP          8'(`OSC_CLK_MHZ)
`define OSC_WRAP          8'(`SYS_CLK_MHZ)

// ----------------------------------------------------------------
// resolution masks and third-of-period offsets
// ----------------------------------------------------------------
`define MASK_8            16'h00ff
`define MASK_10           16'h03ff
`define MASK_12           16'h0fff
`define MASK_16           16'hffff
`define THIRD_8           16'h0055
`define THIRD_10          16'h0155
`define THIRD_12          16'h0555
`define THIRD_16          16'h5555

// ----------------------------------------------------------------
// roll-off fractions in 1/128 units
// ----------------------------------------------------------------
`define FRAC_100          8'h80
`define FRAC_75           8'h60
`define FRAC_55           8'h46
`define FRAC_30           8'h26

`endif

/* File: rtl/led_output_pkg.sv */
// types shared by the led output control block
`default_nettype none
package led_output_pkg;
  typedef enum logic [1:0] {
    DET_OFF0  = 2'h0,
    DET_OFF1  = 2'h1,
    DET_SHORT = 2'h2,
    DET_OPEN  = 2'h3
  } detect_mode_e;

  typedef enum logic [1:0] {
    RES_8  = 2'h0,
    RES_10 = 2'h1,
    RES_12 = 2'h2,
    RES_16 = 2'h3
  } pwm_res_e;
endpackage
`default_nettype wire

/* File: rtl/pwm_cell.sv */
// one pwm output comparator with dc override and gating
`timescale 1ns/100ps
`default_nettype none
module pwm_cell
  import led_output_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic [15:0] phase_cnt,
  input  wire logic [15:0] duty,
  input  wire logic [15:0] res_mask,
  input  wire logic        dc_mode,
  input  wire logic        run,
  output logic             led_on
);
  logic [15:0] duty_m;

  assign duty_m = duty & res_mask;

  // dc forces on, one step stays off, else count below duty
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      led_on <= 1'b0;
    end else if (!run) begin
      led_on <= 1'b0;
    end else if (dc_mode) begin
      led_on <= 1'b1;                              // [RULE13] [RULE16]
    end else begin
      led_on <= (duty_m > 16'h0001) &&             // [RULE15]
                (phase_cnt < duty_m);              // [RULE14]
    end
  end
endmodule
`default_nettype wire

/* File: test/led_string_model.sv */
// led strings and die sensor seen from the output pins
`timescale 1ns/100ps
`default_nettype none
module led_string_model (
  input  wire logic [17:0] open_set,
  input  wire logic [17:0] short_set,
  input  wire logic [7:0]  die_temp,
  output logic      [17:0] led_open_sense,
  output logic      [17:0] led_short_sense,
  output logic      [3:0]  die_over_temp
);
  // comparator level per string, high while the fault is present
  assign led_open_sense  = open_set;
  assign led_short_sense = short_set;
  // sensor trips above 140, 120, 100 and 90 degrees
  assign die_over_temp = {die_temp > 8'h5a, die_temp > 8'h64,
                          die_temp > 8'h78, die_temp > 8'h8c};
endmodule
`default_nettype wire

/* File: test/led_output_properties.sv */
// concurrent checks on the output control block ports
`timescale 1ns/100ps
`default_nettype none
module led_output_checker (
  input wire logic         sys_clk,
  input wire logic         resetn,
  input wire logic         reg_wr,
  input wire logic         reg_rd,
  input wire logic [7:0]   reg_addr,
  input wire logic [7:0]   reg_wdata,
  input wire logic [7:0]   reg_rdata,
  input wire logic         hardware_shutdown_pin,
  input wire logic         software_shutdown_bit,
  input wire logic [143:0] channel_current_scale,
  input wire logic [3:0]   die_over_temp,
  input wire logic [17:0]  led_on,
  input wire logic [287:0] led_current,
  input wire logic         spread_enable,
  input wire logic [1:0]   spread_range,
  input wire logic [1:0]   spread_cycle_time,
  input wire logic         iface_reset,
  input wire logic         regs_reset
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // ----------------------------------------------------------------
  // read side
  // ----------------------------------------------------------------
  a_unmapped_zero:
    assert property (reg_rd && reg_addr inside {8'h75, 8'h79}
      |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_phase_spare:
    assert property (reg_rd && reg_addr == 8'h70 |=> reg_rdata[6:3] == 4'h0)
      else $error("phase spare bits set");
  a_detect_spare:
    assert property (reg_rd && reg_addr inside {8'h71, 8'h74}
      |=> reg_rdata[7:2] == 6'h00) else $error("detect spare bits set");
  a_thermal_spare:
    assert property (reg_rd && reg_addr == 8'h77
      |=> !reg_rdata[5] && reg_rdata[3:2] == 2'h0)
      else $error("thermal spare bits set");

  // ----------------------------------------------------------------
  // resets and outputs
  // ----------------------------------------------------------------
  a_reset_refused:
    assert property (reg_wr && reg_addr == 8'h7f
      && (reg_wdata != 8'h00 || !software_shutdown_bit) |=> !regs_reset)
      else $error("soft reset taken when refused");
  a_reset_taken:
    assert property (hardware_shutdown_pin [*8] ##0 (reg_wr
      && reg_addr == 8'h7f && reg_wdata == 8'h00 && software_shutdown_bit)
      |=> regs_reset) else $error("soft reset not taken");
  a_reset_single:
    assert property (regs_reset |=> !regs_reset)
      else $error("soft reset pulse too long");
  a_iface_quiet:
    assert property (!hardware_shutdown_pin [*8] |-> !iface_reset)
      else $error("interface reset without pin rise");

  property p_spread;
    logic [4:0] v;
    (reg_wr && reg_addr == 8'h78, v = reg_wdata[4:0]) ##1 !reg_wr
      |=> {spread_enable, spread_range, spread_cycle_time} == v;
  endproperty
  a_spread_fields:
    assert property (p_spread) else $error("spread fields wrong");

  property p_current;
    logic [7:0] g;
    logic [7:0] s;
    die_over_temp == 4'h0 [*6] ##0 (reg_wr && reg_addr == 8'h6e,
      g = reg_wdata, s = channel_current_scale[7:0])
      ##1 (!reg_wr && die_over_temp == 4'h0) [*2]
      |=> led_current[15:0] == 16'(g) * 16'(s);
  endproperty
  a_current_scale:
    assert property (p_current) else $error("channel current wrong");

  // main scenarios reached
  c_soft_reset: cover property (regs_reset);
  c_pin_rise: cover property (iface_reset);
  c_dc_group: cover property (led_on[11:0] == 12'hfff);
endmodule
`default_nettype wire

/* File: test/tb_led_channel_output_control.sv */
// self-checking bench for the led output control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
  num_errors++; $display("mismatch %s exp %0h got %0h", n, e, g); end end
module tb_led_channel_output_control;
  logic         sys_clk;
  logic         resetn;
  logic         reg_wr;
  logic         reg_rd;
  logic [7:0]   reg_addr;
  logic [7:0]   reg_wdata;
  logic [7:0]   reg_rdata;
  logic         hardware_shutdown_pin;
  logic         software_shutdown_bit;
  logic [1:0]   pwm_resolution_select;
  logic [287:0] pwm_pending;
  logic [143:0] channel_current_scale;
  logic [17:0]  open_set;
  logic [17:0]  short_set;
  logic [7:0]   die_temp;
  logic [17:0]  led_open_sense;
  logic [17:0]  led_short_sense;
  logic [3:0]   die_over_temp;
  logic [17:0]  led_on;
  logic [287:0] led_current;
  logic         spread_enable;
  logic [1:0]   spread_range;
  logic [1:0]   spread_cycle_time;
  logic         iface_reset;
  logic         regs_reset;
  logic [4:0]   spread_seen;
  int           num_errors;
  int           compares;
  int           cyc;
  int           t;
  int           d;
  int           cnt [18];
  int           rise [18];
  int           thr [4] = '{140, 120, 100, 90};
  int           frac [4] = '{128, 96, 70, 38};
  int           grp [3] = '{2, 6, 12};
  logic [23:0]  rows [8] = '{24'h6e_a5_a5, 24'h70_ff_87, 24'h71_fc_00,
    24'h72_ff_00, 24'h74_ff_00, 24'h77_ff_c3, 24'h78_1f_1f, 24'h79_55_00};

  assign spread_seen = {spread_enable, spread_range, spread_cycle_time};

  led_channel_output_control uut (.sys_clk, .resetn, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .hardware_shutdown_pin,
    .software_shutdown_bit, .pwm_resolution_select, .pwm_pending,
    .channel_current_scale, .led_open_sense, .led_short_sense,
    .die_over_temp, .led_on, .led_current, .spread_enable, .spread_range,
    .spread_cycle_time, .iface_reset, .regs_reset);
  led_string_model far_side (.open_set, .short_set, .die_temp,
    .led_open_sense, .led_short_sense, .die_over_temp);

  // ----------------------------------------------------------------
  // clock, timeout and bus tasks
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // cut a hang short
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 80000) begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic end_of_test;
    if (num_errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] dat);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= dat;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK("reg_rdata", e, reg_rdata)
  endtask

  // settle 3200 cycles, one 8-bit period, then count on cycles and first rises
  task automatic meas(input int n);
    logic [17:0] p;
    tick(3200);
    p = led_on;
    t = 0;
    foreach (cnt[c]) begin
      cnt[c] = 0;
      rise[c] = -1;
    end
    repeat (n) begin
      tick(1);
      foreach (cnt[c]) begin
        cnt[c] += int'(led_on[c]);
        if (led_on[c] && !p[c] && rise[c] < 0)
          rise[c] = t;
      end
      p = led_on;
      t++;
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    resetn <= 1'b0;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= 8'h00;
    reg_wdata <= 8'h00;
    hardware_shutdown_pin <= 1'b1;
    software_shutdown_bit <= 1'b1;
    pwm_resolution_select <= 2'h0;
    pwm_pending <= {80'h0, 16'h0080, 80'h0, 16'h0080, 48'h0, 16'h0480,
                    16'h0000, 16'h0001};
    channel_current_scale <= {{17{8'h40}}, 8'h80};
    open_set <= 18'h2_0381;
    short_set <= 18'h1_c044;
    die_temp <= 8'h14;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (8) @(posedge sys_clk);
    // defaults, write and read back
    foreach (rows[i]) begin
      rchk(rows[i][23:16], 8'h00);
      wr(rows[i][23:16], rows[i][15:8]);
      rchk(rows[i][23:16], rows[i][7:0]);
    end
    for (int i = 0; i < 32; i++) begin
      wr(8'h78, 8'(i));
      tick(2);
      `CHK("spread", 5'(i), spread_seen)
    end
    // thermal flag and roll-off with a hot die
    die_temp <= 8'h82;
    wr(8'h6e, 8'hff);
    for (int i = 0; i < 4; i++) begin
      wr(8'h77, 8'(i));
      rchk(8'h77, {3'h0, 130 > thr[i], 2'h0, 2'(i)});
    end
    foreach (frac[i]) begin
      wr(8'h77, {2'(i), 6'h03});
      tick(3);
      d = (255 * 128 * frac[i]) >> 7;
      `CHK("led_current", 16'(d), led_current[15:0])
    end
    die_temp <= 8'h14;
    // open capture, short capture, then no capture from 01
    for (int i = 0; i < 3; i++) begin
      wr(8'h71, {7'h00, i == 2});
      wr(8'h71, {6'h00, 1'b1, i != 1});
      d = (i == 0) ? open_set : short_set;
      rchk(8'h72, d[7:0]);
      rchk(8'h73, d[15:8]);
      rchk(8'h74, {6'h00, d[17:16]});
    end
    // pwm duty, update and phase
    wr(8'h70, 8'h00);
    wr(8'h49, 8'h01);
    meas(3200);
    `CHK("refused update", 0, cnt[2])
    wr(8'h49, 8'h00);
    meas(3200);
    `CHK("one step", 0, cnt[0])
    `CHK("zero duty", 0, cnt[1])
    `CHK("half duty", 1600, cnt[2])
    `CHK("no delay", rise[2], rise[6])
    wr(8'h70, 8'h80);
    meas(3200);
    d = (rise[6] - rise[2] + 3200) % 3200;
    `CHK("delay two", 1'b1, d inside {[1055:1070]})
    d = (rise[12] - rise[6] + 3200) % 3200;
    `CHK("delay three", 1'b1, d inside {[1055:1070]})
    for (int g = 0; g < 3; g++) begin
      wr(8'h70, 8'(1 << g));
      meas(3200);
      d = (rise[grp[g]] - rise[grp[(g + 1) % 3]] + 3200) % 3200;
      `CHK("half shift", 1'b1, d inside {[1595:1605]})
    end
    // dc mode per output range
    wr(8'h78, 8'h20);
    tick(3);
    `CHK("dc low", 12'hfff, led_on[11:0])
    wr(8'h78, 8'h40);
    tick(3);
    `CHK("dc high", 6'h3f, led_on[17:12])
    `CHK("dc cleared", 1'b0, led_on[1])
    wr(8'h78, 8'h00);
    pwm_resolution_select <= 2'h1;
    meas(12800);
    `CHK("ten bit", 1600, cnt[2])
    // refused soft resets, pin rise, then a real soft reset
    @(posedge sys_clk);
    software_shutdown_bit <= 1'b0;
    wr(8'h7f, 8'h00);
    rchk(8'h6e, 8'hff);
    software_shutdown_bit <= 1'b1;
    wr(8'h7f, 8'h01);
    rchk(8'h6e, 8'hff);
    hardware_shutdown_pin <= 1'b0;
    repeat (10) @(posedge sys_clk);
    hardware_shutdown_pin <= 1'b1;
    d = 0;
    repeat (12) begin
      tick(1);
      d += int'(iface_reset);
    end
    `CHK("iface pulses", 1, d)
    rchk(8'h6e, 8'hff);
    wr(8'h7f, 8'h00);
    rchk(8'h6e, 8'h00);
    rchk(8'h70, 8'h00);
    end_of_test();
  end
endmodule

bind led_channel_output_control led_output_checker chk (.sys_clk, .resetn,
  .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .hardware_shutdown_pin,
  .software_shutdown_bit, .channel_current_scale, .die_over_temp, .led_on,
  .led_current, .spread_enable, .spread_range, .spread_cycle_time,
  .iface_reset, .regs_reset);
`default_nettype wire
